/* File: design/lane_align_map.vh */
// Register offsets, field values and constants for the lane alignment configuration transmitter
`ifndef LANE_ALIGN_MAP_VH
`define LANE_ALIGN_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MFLEN 8'h04
`define OFS_STATUS 8'h08
`define OFS_SAMPLE 8'h0C
`define OFS_DATA 8'h10
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_ILAS_EN 0
`define CTRL_TWO_LANE 1
`define CTRL_MF_OVR 2
`define CTRL_SCRAMBLE 3
`define CTRL_TWOS_COMP 4
`define CTRL_CONV_EN 5
`define CTRL_RESET 32'h0000_0000
// ----------------------------------------
// Configuration field values
// ----------------------------------------
`define CFG_RES_N 5'h0D
`define CFG_BITS_NP 5'h0F
`define CFG_K_ONE_LANE 5'h08
`define CFG_K_TWO_LANE 5'h10
`define CFG_L_TWO_LANE 5'h01
`define CFG_OCTETS 14
`define CFG_LAST 4'hD
// ----------------------------------------
// Conversion timing
// ----------------------------------------
`define CONV_LATENCY 20
`define SAMPLE_BITS 14
`define RATE_MSPS 160
`endif

/* File: design/sample_fifo.v */
// Synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Storage has no reset; pointers guard reads
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // Pointers and fill count
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

/* File: design/lane_alignment_config_tx.v */
// Lane alignment configuration octet generator with converter sample pipeline and AXI4-Lite registers
`include "lane_align_map.vh"
module lane_alignment_config_tx #(
  parameter LATENCY = `CONV_LATENCY,
  parameter FIFO_DEPTH = 32
) (
  input wire clk,
  input wire rst_b,
  input wire [13:0] sample_in,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [7:0] lane0_octet,
  output reg [7:0] lane1_octet,
  output reg cfg_valid,
  output reg [3:0] cfg_index
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] ctrl_r;
  reg [4:0] multiframe_length_value_r;
  reg [31:0] aw_r;
  reg aw_ok_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  reg wd_ok_r;
  reg ilas_done_r;
  wire ilas_en = ctrl_r[`CTRL_ILAS_EN];
  wire two_lane = ctrl_r[`CTRL_TWO_LANE];
  wire mf_ovr = ctrl_r[`CTRL_MF_OVR];
  wire scramble_select = ctrl_r[`CTRL_SCRAMBLE];
  wire twos_comp = ctrl_r[`CTRL_TWOS_COMP];
  wire conv_en = ctrl_r[`CTRL_CONV_EN];
  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  // Default follows lane setting; override only when bit is one
  wire [4:0] k_field = mf_ovr ? multiframe_length_value_r :
    (two_lane ? `CFG_K_TWO_LANE : `CFG_K_ONE_LANE);
  wire [4:0] l_field = two_lane ? `CFG_L_TWO_LANE : 5'h00;
  wire [7:0] f_field = two_lane ? 8'h00 : 8'h01;
  // Octet builder shared by both lanes, differs only in lane id
  function [7:0] cfg_octet;
    input [3:0] idx;
    input [4:0] lid;
    input [4:0] lf;
    input [7:0] ff;
    input [4:0] kf;
    input scr;
    reg [7:0] sum;
    begin
      sum = 8'h00;
      case (idx)
        4'h0: cfg_octet = 8'h00;
        4'h1: cfg_octet = 8'h00;
        4'h2: cfg_octet = {3'b000, lid};
        4'h3: cfg_octet = {scr, 2'b00, lf};
        4'h4: cfg_octet = ff;
        4'h5: cfg_octet = {3'b000, kf};
        4'h6: cfg_octet = 8'h00;
        4'h7: cfg_octet = {3'b000, `CFG_RES_N};
        4'h8: cfg_octet = {3'b000, `CFG_BITS_NP};
        4'h9: cfg_octet = 8'h00;
        4'hA: cfg_octet = 8'h00;
        4'hB: cfg_octet = 8'h00;
        4'hC: cfg_octet = 8'h00;
        4'hD: begin
          // Sum of field values, wraps at 256
          sum = {3'b000, lid} + {7'b0000000, scr} + {3'b000, lf} + ff + {3'b000, kf} +
            {3'b000, `CFG_RES_N} + {3'b000, `CFG_BITS_NP};
          cfg_octet = sum;
        end
        default: cfg_octet = 8'h00;
      endcase
    end
  endfunction
  // ----------------------------------------
  // Sample pipeline
  // ----------------------------------------
  reg [13:0] samp_s1_r;
  reg [13:0] samp_s2_r;
  reg [13:0] pipe_r [0:LATENCY-1];
  reg [LATENCY-1:0] pv_r;
  // Input pin passes two flops; the first one is the sampling edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_s1_r <= 14'h0000;
      samp_s2_r <= 14'h0000;
    end else begin
      samp_s1_r <= sample_in;
      samp_s2_r <= samp_s1_r;
    end
  end
  // One stage per edge; format applied on entry by flipping the sign bit
  genvar g;
  generate
    for (g = 0; g < LATENCY; g = g + 1) begin : stage
      if (g == 0) begin : first
        always @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            pipe_r[g] <= 14'h0000;
            pv_r[g] <= 1'b0;
          end else begin
            pipe_r[g] <= {samp_s2_r[13] ^ twos_comp, samp_s2_r[12:0]};
            pv_r[g] <= conv_en;
          end
        end
      end else begin : rest
        always @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            pipe_r[g] <= 14'h0000;
            pv_r[g] <= 1'b0;
          end else begin
            pipe_r[g] <= pipe_r[g-1];
            pv_r[g] <= pv_r[g-1];
          end
        end
      end
    end
  endgenerate
  // Samples buffer ahead of the link; full stalls nothing upstream, so overflow drops
  wire fifo_in_ready;
  wire [31:0] fifo_out;
  wire fifo_valid;
  wire fifo_pop = fifo_valid && ilas_done_r && !cfg_valid;
  sample_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data({18'h0_0000, pipe_r[LATENCY-1]}),
    .in_valid(pv_r[LATENCY-1]),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  reg ovf_r;
  // ----------------------------------------
  // Alignment sequence and link output
  // ----------------------------------------
  // Octet counter walks 0..13 once per enable; samples follow afterwards
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_valid <= 1'b0;
      cfg_index <= 4'h0;
      ilas_done_r <= 1'b0;
      lane0_octet <= 8'h00;
      lane1_octet <= 8'h00;
      ovf_r <= 1'b0;
    end else begin
      if (pv_r[LATENCY-1] && !fifo_in_ready) begin
        ovf_r <= 1'b1;
      end
      if (!ilas_en) begin
        cfg_valid <= 1'b0;
        cfg_index <= 4'h0;
        ilas_done_r <= 1'b0;
        lane0_octet <= 8'h00;
        lane1_octet <= 8'h00;
      end else if (!ilas_done_r) begin
        cfg_valid <= 1'b1;
        lane0_octet <= cfg_octet(cfg_index, 5'h00, l_field, f_field, k_field, scramble_select);
        lane1_octet <= cfg_octet(cfg_index, 5'h01, l_field, f_field, k_field, scramble_select);
        if (cfg_index == `CFG_LAST) begin
          ilas_done_r <= 1'b1;
          cfg_index <= 4'h0;
        end else begin
          cfg_index <= cfg_index + 4'h1;
        end
      end else begin
        cfg_valid <= 1'b0;
        // Two lanes split MSB and LSB octets; one lane carries MSB only
        if (fifo_pop) begin
          lane0_octet <= {2'b00, fifo_out[13:8]};
          lane1_octet <= two_lane ? fifo_out[7:0] : 8'h00;
        end
      end
    end
  end
  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data captured independently, response after both
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_ok_r <= 1'b0;
      wd_ok_r <= 1'b0;
      aw_r <= 32'h0000_0000;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      ctrl_r <= `CTRL_RESET;
      multiframe_length_value_r <= 5'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= s_axi_awaddr;
        aw_ok_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        wd_ok_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_ok_r && wd_ok_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        aw_ok_r <= 1'b0;
        wd_ok_r <= 1'b0;
        if (aw_r[7:0] == `OFS_CTRL && ws_r[0]) begin
          ctrl_r[7:0] <= wd_r[7:0];
        end else if (aw_r[7:0] == `OFS_MFLEN && ws_r[0]) begin
          multiframe_length_value_r <= wd_r[4:0];
        end else if (aw_r[7:0] != `OFS_CTRL && aw_r[7:0] != `OFS_MFLEN) begin
          s_axi_bresp <= 2'b10;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Read: one cycle after address accepted
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr[7:0])
          `OFS_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_r[7:0]};
          `OFS_MFLEN: s_axi_rdata <= {27'h000_0000, multiframe_length_value_r};
          `OFS_STATUS: s_axi_rdata <= {25'h000_0000, ovf_r, fifo_valid, cfg_index, ilas_done_r};
          `OFS_SAMPLE: s_axi_rdata <= {18'h0_0000, pipe_r[LATENCY-1]};
          `OFS_DATA: s_axi_rdata <= {3'b000, k_field, 3'b000, l_field, f_field, 8'h00};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* File: bench/lane_align_asserts.sv */
// Port-level assertion checker for the lane alignment transmitter
module lane_align_asserts (
  input wire clk,
  input wire rst_b,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] lane0_octet,
  input wire [7:0] lane1_octet,
  input wire cfg_valid,
  input wire [3:0] cfg_index
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Bus handshakes and alignment octet framing
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while responding");
  a_cfg_run_len: assert property ($rose(cfg_valid) |-> cfg_valid[*8] ##1 cfg_valid[*6] ##1 !cfg_valid)
    else $error("alignment run not fourteen octets");
  a_cfg_start: assert property ($rose(cfg_valid) |-> cfg_index == 4'h1 && lane0_octet == 8'h00)
    else $error("sequence does not open with zero device id");
  a_index_step: assert property (cfg_valid && $past(cfg_valid) |->
    cfg_index == (($past(cfg_index) == 4'hD) ? 4'h0 : $past(cfg_index) + 4'h1))
    else $error("octet index skipped");
  a_res_octets: assert property (cfg_valid && cfg_index == 4'h8 |-> lane0_octet == 8'h0D ##1 lane0_octet == 8'h0F)
    else $error("resolution fields wrong");
  a_reserved_zero: assert property (cfg_valid && cfg_index > 4'hB |-> lane0_octet == 8'h00 || cfg_index == 4'hE)
    else $error("reserved octet not zero");
endmodule
bind lane_alignment_config_tx lane_align_asserts u_lane_align_asserts (.clk(clk), .rst_b(rst_b),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .lane0_octet(lane0_octet), .lane1_octet(lane1_octet), .cfg_valid(cfg_valid), .cfg_index(cfg_index));

/* File: bench/lane_rx_model.sv */
// Receiver-side sink that captures the alignment octets of both lanes
module lane_rx_model (
  input wire clk,
  input wire rst_b,
  input wire [7:0] lane0_octet,
  input wire [7:0] lane1_octet,
  input wire cfg_valid,
  input wire [3:0] cfg_index,
  output logic got,
  output logic [7:0] o0 [0:13],
  output logic [7:0] o1 [0:13]
);
  timeunit 1ns;
  timeprecision 1ns;
  // Octet on the lanes trails the index by one; the last octet shows with index wrapped to zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      got <= 1'b0;
    end else begin
      got <= cfg_valid && cfg_index == 4'h0;
      if (cfg_valid) begin
        o0[(cfg_index == 4'h0) ? 4'hD : cfg_index - 4'h1] <= lane0_octet;
        o1[(cfg_index == 4'h0) ? 4'hD : cfg_index - 4'h1] <= lane1_octet;
      end
    end
  end
endmodule

/* File: bench/lane_alignment_config_tx_bench.sv */
// Self-checking bench for the lane alignment configuration transmitter
`include "lane_align_map.vh"
module lane_alignment_config_tx_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cfg_valid, got;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
  logic [13:0] sample_in, v;
  logic [1:0] rresp, rd_r;
  logic [7:0] lane0_octet, lane1_octet;
  logic [7:0] o0 [0:13];
  logic [7:0] o1 [0:13];
  logic [3:0] cfg_index;
  logic [4:0] kv;
  logic two, ovr, scr;
  int fails, samples_checked, cyc, m, i;
  lane_alignment_config_tx u_lane_alignment_config_tx (.clk(clk), .rst_b(rst_b), .sample_in(sample_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lane0_octet(lane0_octet), .lane1_octet(lane1_octet), .cfg_valid(cfg_valid), .cfg_index(cfg_index));
  lane_rx_model u_lane_rx_model (.clk(clk), .rst_b(rst_b), .lane0_octet(lane0_octet),
    .lane1_octet(lane1_octet), .cfg_valid(cfg_valid), .cfg_index(cfg_index), .got(got), .o0(o0), .o1(o1));
  // ----------------------------------------
  // Clock, run limit and shared tasks
  // ----------------------------------------
  always #50 clk = ~clk;
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Address and data go out together; each drops on its own acceptance
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Expected octet from the lane id and the mode settings
  function automatic logic [7:0] exp_oct(int n, logic [4:0] lid);
    logic [7:0] k, f, l;
    k = ovr ? {3'h0, kv} : (two ? 8'h10 : 8'h08);
    l = {7'h0, two};
    f = {7'h0, !two};
    case (n)
      2: return {3'h0, lid};
      3: return {scr, 2'h0, l[4:0]};
      4: return f;
      5: return k;
      7: return 8'h0D;
      8: return 8'h0F;
      13: return lid + scr + l + f + k + 8'h0D + 8'h0F;
      default: return 8'h00;
    endcase
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, sample_in, cyc, fails, samples_checked} = '0;
    rst_b = 1'b0;
    v = $urandom(32'h0000_cee7);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    chk(cfg_valid, 0);
    rd(32'h0000_0020);
    chk({30'h0, rd_r}, 32'h0000_0002);
    chk(rd_v, 32'h0000_0000);
    // Every lane mode with and without the multiframe override
    for (m = 0; m < 4; m++) begin
      {ovr, two} = m[1:0];
      kv = $urandom;
      scr = $urandom;
      wr(`OFS_MFLEN, {27'h0, kv});
      wr(`OFS_CTRL, {28'h0, scr, ovr, two, 1'b0});
      wr(`OFS_CTRL, {28'h0, scr, ovr, two, 1'b1});
      do @(posedge clk); while (!got);
      for (i = 0; i < 14; i++) begin
        chk(o0[i], exp_oct(i, 5'h00));
        if (two)
          chk(o1[i], exp_oct(i, 5'h01));
      end
    end
    // Old sample must still show before the 22-cycle path has elapsed
    for (m = 0; m < 2; m++) begin
      wr(`OFS_CTRL, 32'h0000_0020 | (m << 4));
      sample_in <= v;
      repeat (30) @(posedge clk);
      sample_in <= $urandom;
      repeat (12) @(posedge clk);
      rd(`OFS_SAMPLE);
      chk(rd_v, {18'h0, v ^ (m ? 14'h2000 : 14'h0000)});
      v = sample_in;
      repeat (30) @(posedge clk);
      rd(`OFS_SAMPLE);
      chk(rd_v, {18'h0, v ^ (m ? 14'h2000 : 14'h0000)});
    end
    test_done();
  end
endmodule
